//--- core/sample_clock_pkg.sv
package sample_clock_pkg;

	// Sample layout
	localparam int SAMPLE_W = 12;
	localparam int MARKED_MSBS = 11;
	localparam int NARROW_W = 8;

	// Aperture delay settings, 256 each
	localparam int COARSE_W = 8;
	localparam int FINE_W = 8;

	// Ramp pacing: steps per window of device clock cycles
	localparam int RAMP_WINDOW_CYC = 384;
	localparam int SLOW_STEPS = 1;
	localparam int FAST_STEPS = 4;
	localparam int SLOW_INTERVAL_CYC = RAMP_WINDOW_CYC / SLOW_STEPS;
	localparam int FAST_INTERVAL_CYC = RAMP_WINDOW_CYC / FAST_STEPS;
	localparam int RAMP_TIMER_W = 9;

	// Trigger mark capture
	localparam int SYNC_STAGES = 2;

	// Reference period checker
	localparam int LMFC_PERIOD_W = 16;

	// Values after reset
	localparam logic [COARSE_W-1:0] COARSE_RESET = 8'h00;
	localparam logic [FINE_W-1:0] FINE_RESET = 8'h00;
	localparam logic [RAMP_TIMER_W-1:0] TIMER_RESET = 9'h000;
	localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 12'h000;
	localparam logic [LMFC_PERIOD_W-1:0] PHASE_RESET = 16'h0000;

endpackage : sample_clock_pkg

//--- core/mark_delay_line.sv
`timescale 1ns/10ps
`default_nettype none

module mark_delay_line #(
	parameter int DEPTH = 2,
	parameter int WIDTH = 1
) (
	input wire logic mclk_in, // Device clock
	input wire logic rstn_in, // Async reset, active low
	input wire logic [WIDTH-1:0] data_in, // Value entering the line
	output logic [WIDTH-1:0] data_out // Value DEPTH cycles later, registered
);

	generate
		if (DEPTH < 1) begin : g_bad_depth
			$error("mark_delay_line needs DEPTH of at least 1");
		end
	endgenerate

	logic [WIDTH-1:0] stage_reg [DEPTH];
	logic [WIDTH-1:0] stage_next [DEPTH];

	// Shift by one stage each clock
	always_comb begin
		stage_next[0] = data_in;
		for (int i = 1; i < DEPTH; i++) begin
			stage_next[i] = stage_reg[i-1];
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage_reg[i] <= '0;
			end
		end else begin
			stage_reg <= stage_next;
		end
	end

	assign data_out = stage_reg[DEPTH-1];

endmodule : mark_delay_line

`default_nettype wire

//--- core/sample_clock_delay_and_timestamp.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Wide sample: eleven upper bits plus mark.
// - Mark path latency matches converter core.
// - Narrow samples carry mark in LSB.
// - Asynchronous trigger is synchronised, then sampled.
// - Decimating formats disable marking; reference used.
// - Dual mode: one rising sample per clock.
// - Single mode: rising and falling samples.
// - One device clock runs everything here.
// - Half period invert delays by half clock.
// - Coarse and fine: 256 settings, independent.
// - Delay setting shifts all internal clocks.
// - Delay changes live; ramp recommended.
// - Ramp steps effective coarse toward target.
// - Ramp pace: one or four per 384.
// - Each coarse write while enabled restarts ramp.

module sample_clock_delay_and_timestamp
	import sample_clock_pkg::*;
#(
	parameter int CORE_LATENCY = 4 // Converter core latency in clocks
) (
	input wire logic mclk_in, // Device clock, 125 MHz
	input wire logic rstn_in, // Async reset, active low
	input wire logic [SAMPLE_W-1:0] conv_first_in, // Core sample, rising edge
	input wire logic [SAMPLE_W-1:0] conv_second_in, // Core sample, falling edge or channel B
	input wire logic single_channel_in, // 1 = single channel, dual edge
	input wire logic narrow_samples_in, // 1 = 8-bit output format
	input wire logic decimation_active_in, // Link format uses decimation
	input wire logic timestamp_enable_in, // Sample mark enable
	input wire logic trigger_mark_input_in, // Asynchronous trigger
	input wire logic clock_half_period_invert_in, // Invert device clock
	input wire logic [COARSE_W-1:0] aperture_delay_coarse_in, // Coarse value to write
	input wire logic coarse_write_in, // Write strobe for coarse value
	input wire logic [FINE_W-1:0] aperture_delay_fine_in, // Fine delay setting
	input wire logic delay_ramp_enable_in, // Ramp toward written coarse value
	input wire logic delay_ramp_speed_in, // 0 = slow, 1 = fast
	input wire logic sysref_in, // System reference, synchronous
	input wire logic [LMFC_PERIOD_W-1:0] lmfc_period_in, // Multiframe period in clocks
	input wire logic sysref_error_clear_in, // Clears period error flag
	output logic [SAMPLE_W-1:0] sample_first_out, // Output sample, rising edge
	output logic [SAMPLE_W-1:0] sample_second_out, // Output sample, falling or B
	output logic second_is_fall_out, // Second sample is falling edge
	output logic clock_invert_out, // Applied half period invert
	output logic [COARSE_W-1:0] coarse_effective_out, // Applied coarse delay
	output logic [FINE_W-1:0] fine_effective_out, // Applied fine delay
	output logic ramp_busy_out, // Ramp still moving
	output logic sysref_error_out // Sticky reference period error
);

	localparam int MARK_DEPTH = CORE_LATENCY - SYNC_STAGES;
	localparam int MARK_PAST = CORE_LATENCY + 1;
	localparam int SLOW_LAST = SLOW_INTERVAL_CYC - 1;
	localparam int FAST_LAST = FAST_INTERVAL_CYC - 1;

	generate
		if (CORE_LATENCY < SYNC_STAGES + 1) begin : g_bad_latency
			$error("CORE_LATENCY too small for the trigger synchroniser");
		end
	endgenerate

	// Overlay the mark on one sample; pass untouched when marking is off
	function automatic logic [SAMPLE_W-1:0] mark_sample(input logic [SAMPLE_W-1:0] conv,
			input logic mark, input logic active, input logic narrow);
		logic [SAMPLE_W-1:0] res;
		res = conv;
		if (active && narrow) begin
			res = {{(SAMPLE_W-NARROW_W){1'b0}}, conv[SAMPLE_W-1 -: NARROW_W-1], mark};
		end else if (active) begin
			res = {conv[SAMPLE_W-1 -: MARKED_MSBS], mark};
		end
		return res;
	endfunction : mark_sample

	// Trigger synchroniser; first stage feeds only the second
	logic sync1_reg, sync2_reg;
	logic mark_aligned;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= trigger_mark_input_in;
			sync2_reg <= sync1_reg;
		end
	end

	// The synchroniser eats part of the core latency; the line makes up the rest
	mark_delay_line #(
		.DEPTH(MARK_DEPTH),
		.WIDTH(1)
	) u_mark_delay (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.data_in(sync2_reg),
		.data_out(mark_aligned)
	);

	// Output sample stage
	logic [SAMPLE_W-1:0] first_reg, first_next, second_reg, second_next;
	logic fall_reg, fall_next;
	logic mark_active;

	always_comb begin
		mark_active = timestamp_enable_in && !decimation_active_in;
		first_next = mark_sample(conv_first_in, mark_aligned, mark_active, narrow_samples_in);
		second_next = mark_sample(conv_second_in, mark_aligned, mark_active, narrow_samples_in);
		fall_next = single_channel_in;
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			first_reg <= SAMPLE_RESET;
			second_reg <= SAMPLE_RESET;
			fall_reg <= 1'b0;
		end else begin
			first_reg <= first_next;
			second_reg <= second_next;
			fall_reg <= fall_next;
		end
	end

	// Aperture delay and coarse ramp
	logic [COARSE_W-1:0] eff_reg, eff_next, target_reg, target_next;
	logic [FINE_W-1:0] fine_reg, fine_next;
	logic inv_reg, inv_next;
	logic [RAMP_TIMER_W-1:0] timer_reg, timer_next, interval_last;
	logic busy_reg, busy_next;
	logic speed_prev_reg, speed_prev_next;

	// Changing the pace restarts the window so a stale count cannot fire early
	always_comb begin
		interval_last = delay_ramp_speed_in ? RAMP_TIMER_W'(FAST_LAST) : RAMP_TIMER_W'(SLOW_LAST);
		eff_next = eff_reg;
		target_next = target_reg;
		timer_next = timer_reg;
		fine_next = aperture_delay_fine_in;
		inv_next = clock_half_period_invert_in;
		speed_prev_next = delay_ramp_speed_in;
		if (coarse_write_in) begin
			target_next = aperture_delay_coarse_in;
			timer_next = TIMER_RESET;
			if (!delay_ramp_enable_in) begin
				eff_next = aperture_delay_coarse_in;
			end
		end else if (!delay_ramp_enable_in) begin
			eff_next = target_reg;
			timer_next = TIMER_RESET;
		end else if (delay_ramp_speed_in != speed_prev_reg || eff_reg == target_reg) begin
			timer_next = TIMER_RESET;
		end else if (timer_reg == interval_last) begin
			timer_next = TIMER_RESET;
			eff_next = (eff_reg < target_reg) ? eff_reg + 1'b1 : eff_reg - 1'b1;
		end else begin
			timer_next = timer_reg + 1'b1;
		end
		busy_next = delay_ramp_enable_in && (eff_next != target_next);
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			eff_reg <= COARSE_RESET;
			target_reg <= COARSE_RESET;
			timer_reg <= TIMER_RESET;
			fine_reg <= FINE_RESET;
			inv_reg <= 1'b0;
			busy_reg <= 1'b0;
			speed_prev_reg <= 1'b0;
		end else begin
			eff_reg <= eff_next;
			target_reg <= target_next;
			timer_reg <= timer_next;
			fine_reg <= fine_next;
			inv_reg <= inv_next;
			busy_reg <= busy_next;
			speed_prev_reg <= speed_prev_next;
		end
	end

	// Reference period checker: every edge must land on the first edge's phase
	logic sr_prev_reg, sr_prev_next, armed_reg, armed_next, err_reg, err_next;
	logic [LMFC_PERIOD_W-1:0] phase_reg, phase_next, ref_phase_reg, ref_phase_next;
	logic sr_edge, sr_mismatch;

	always_comb begin
		sr_prev_next = sysref_in;
		sr_edge = sysref_in && !sr_prev_reg;
		phase_next = (phase_reg + 1'b1 >= lmfc_period_in) ? PHASE_RESET : phase_reg + 1'b1;
		armed_next = armed_reg;
		ref_phase_next = ref_phase_reg;
		sr_mismatch = sr_edge && armed_reg && (phase_reg != ref_phase_reg);
		if (sr_edge && !armed_reg) begin
			armed_next = 1'b1;
			ref_phase_next = phase_reg;
		end
		err_next = sr_mismatch || (err_reg && !sysref_error_clear_in);
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sr_prev_reg <= 1'b0;
			armed_reg <= 1'b0;
			err_reg <= 1'b0;
			phase_reg <= PHASE_RESET;
			ref_phase_reg <= PHASE_RESET;
		end else begin
			sr_prev_reg <= sr_prev_next;
			armed_reg <= armed_next;
			err_reg <= err_next;
			phase_reg <= phase_next;
			ref_phase_reg <= ref_phase_next;
		end
	end

	// Delay settings leave here for the whole clock tree of the device
	assign clock_invert_out = inv_reg;
	assign coarse_effective_out = eff_reg;
	assign fine_effective_out = fine_reg;
	assign ramp_busy_out = busy_reg;
	assign sample_first_out = first_reg;
	assign sample_second_out = second_reg;
	assign second_is_fall_out = fall_reg;
	assign sysref_error_out = err_reg;

	// Helper: warm-up after reset so history-based checks see real inputs
	logic [3:0] warm_reg;
	logic warm;
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			warm_reg <= 4'h0;
		end else if (warm_reg != 4'hF) begin
			warm_reg <= warm_reg + 4'h1;
		end
	end
	assign warm = (warm_reg > 4'(MARK_PAST));

	// Helper: cycles since the ramp window last restarted
	logic [RAMP_TIMER_W-1:0] gap_reg;
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			gap_reg <= TIMER_RESET;
		end else if (coarse_write_in || !delay_ramp_enable_in || eff_reg == target_reg
				|| delay_ramp_speed_in != speed_prev_reg || gap_reg == interval_last) begin
			gap_reg <= TIMER_RESET;
		end else begin
			gap_reg <= gap_reg + 1'b1;
		end
	end

	property p_wide_mark;
		@(posedge mclk_in) disable iff (!rstn_in)
		warm && timestamp_enable_in && !decimation_active_in && !narrow_samples_in |=>
			sample_first_out == {$past(conv_first_in[SAMPLE_W-1:1]),
			$past(trigger_mark_input_in, MARK_PAST)};
	endproperty
	a_wide_mark: assert property (p_wide_mark) else $error("wide mark misplaced");

	property p_narrow_mark;
		@(posedge mclk_in) disable iff (!rstn_in)
		warm && timestamp_enable_in && !decimation_active_in && narrow_samples_in |=>
			sample_second_out[NARROW_W-1:0] == {$past(conv_second_in[SAMPLE_W-1 -: NARROW_W-1]),
			$past(trigger_mark_input_in, MARK_PAST)} && sample_second_out[SAMPLE_W-1:NARROW_W] == '0;
	endproperty
	a_narrow_mark: assert property (p_narrow_mark) else $error("narrow mark misplaced");

	property p_no_mark;
		@(posedge mclk_in) disable iff (!rstn_in)
		warm && (!timestamp_enable_in || decimation_active_in) |=>
			sample_first_out == $past(conv_first_in) && sample_second_out == $past(conv_second_in);
	endproperty
	a_no_mark: assert property (p_no_mark) else $error("sample altered without marking");

	property p_edge_mode;
		@(posedge mclk_in) disable iff (!rstn_in)
		$rose(single_channel_in) |=> second_is_fall_out ##1 (second_is_fall_out || !$past(single_channel_in));
	endproperty
	a_edge_mode: assert property (p_edge_mode) else $error("edge mode not followed");

	property p_direct_write;
		@(posedge mclk_in) disable iff (!rstn_in)
		coarse_write_in && !delay_ramp_enable_in |=>
			coarse_effective_out == $past(aperture_delay_coarse_in) && !ramp_busy_out;
	endproperty
	a_direct_write: assert property (p_direct_write) else $error("direct coarse write lost");

	property p_ramp_hold;
		@(posedge mclk_in) disable iff (!rstn_in)
		coarse_write_in && delay_ramp_enable_in |=>
			$stable(coarse_effective_out) && (ramp_busy_out == (target_reg != coarse_effective_out));
	endproperty
	a_ramp_hold: assert property (p_ramp_hold) else $error("ramp did not start from write");

	property p_unit_step;
		@(posedge mclk_in) disable iff (!rstn_in)
		$past(delay_ramp_enable_in) && !$past(coarse_write_in) && $changed(coarse_effective_out) |->
			(coarse_effective_out == $past(coarse_effective_out) + 1'b1
			&& $past(coarse_effective_out) < target_reg + 1'b0)
			|| (coarse_effective_out == $past(coarse_effective_out) - 1'b1
			&& $past(coarse_effective_out) > target_reg);
	endproperty
	a_unit_step: assert property (p_unit_step) else $error("ramp step wrong size or overshoot");

	property p_step_spacing;
		@(posedge mclk_in) disable iff (!rstn_in)
		$past(delay_ramp_enable_in) && !$past(coarse_write_in) && $changed(coarse_effective_out) |->
			$past(gap_reg) == $past(interval_last);
	endproperty
	a_step_spacing: assert property (p_step_spacing) else $error("ramp step at wrong spacing");

	property p_fine_inv;
		@(posedge mclk_in) disable iff (!rstn_in)
		warm |-> fine_effective_out == $past(aperture_delay_fine_in)
			&& clock_invert_out == $past(clock_half_period_invert_in);
	endproperty
	a_fine_inv: assert property (p_fine_inv) else $error("fine or invert not applied");

	property p_sysref_err;
		@(posedge mclk_in) disable iff (!rstn_in)
		sysref_in && !sr_prev_reg && armed_reg && phase_reg != ref_phase_reg |=>
			sysref_error_out [*2];
	endproperty
	a_sysref_err: assert property (p_sysref_err) else $error("reference period error missed");

endmodule : sample_clock_delay_and_timestamp

`default_nettype wire

//--- dv/ref_trig_source.sv
`timescale 1ns/10ps
`default_nettype none

// Far side: reference generator and trigger source
module ref_trig_source (
	input wire logic mclk_in, // Device clock
	input wire logic run_in, // Reference pulses on
	input wire logic slip_in, // Stretch each period by a cycle
	input wire logic [15:0] period_in, // Reference period, clocks
	output logic sysref_out, // Periodic reference pulse
	output logic trig_out // Trigger level
);
	int cnt = 0;
	logic pulse = 1'b0;
	logic [7:0] lf = 8'h5A;

	// Periodic while run_in; period is period_in clocks, one more with slip_in
	always @(posedge mclk_in) begin
		cnt <= (cnt + 1 >= int'(period_in) + int'(slip_in)) ? 0 : cnt + 1;
		pulse <= run_in && (cnt == 0);
	end
	// Trigger moves on the falling edge, so it is unrelated to sampling
	always @(negedge mclk_in) begin
		lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
	end
	assign sysref_out = pulse;
	assign trig_out = lf[0];
endmodule : ref_trig_source

`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import sample_clock_pkg::*;
	localparam int LAT = 4;
	logic mclk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [11:0] cf = 12'h000, cs = 12'h000, sf, ss, ef = 12'h000, es = 12'h000;
	logic single = 1'b0, narrow = 1'b0, decim = 1'b0, ts_en = 1'b0, inv = 1'b0;
	logic cwr = 1'b0, ramp_en = 1'b0, speed = 1'b0, eclr = 1'b0, run = 1'b0;
	logic slip = 1'b0, efall = 1'b0, trig, sysref, fall, inv_o, busy, serr, mk;
	logic [7:0] coarse = 8'h00, fine = 8'h00, ceff, feff;
	logic [15:0] period = 16'h0010;
	logic [3:0] mode = 4'h0;
	logic pin_q[$];
	int seed = 33038;
	int quiet = 8;
	int n_mismatch = 0;
	int comparisons = 0;

	always #4 mclk_in = ~mclk_in;

	sample_clock_delay_and_timestamp #(.CORE_LATENCY(LAT)) dut_u (
		.mclk_in(mclk_in), .rstn_in(rstn_in), .conv_first_in(cf), .conv_second_in(cs),
		.single_channel_in(single), .narrow_samples_in(narrow),
		.decimation_active_in(decim), .timestamp_enable_in(ts_en),
		.trigger_mark_input_in(trig), .clock_half_period_invert_in(inv),
		.aperture_delay_coarse_in(coarse), .coarse_write_in(cwr),
		.aperture_delay_fine_in(fine), .delay_ramp_enable_in(ramp_en),
		.delay_ramp_speed_in(speed), .sysref_in(sysref), .lmfc_period_in(period),
		.sysref_error_clear_in(eclr), .sample_first_out(sf), .sample_second_out(ss),
		.second_is_fall_out(fall), .clock_invert_out(inv_o),
		.coarse_effective_out(ceff), .fine_effective_out(feff),
		.ramp_busy_out(busy), .sysref_error_out(serr));

	ref_trig_source src_u (.mclk_in(mclk_in), .run_in(run), .slip_in(slip),
		.period_in(16'h0020), .sysref_out(sysref), .trig_out(trig));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	// Marking on: wide keeps upper bits, narrow the top seven, mark takes the LSB
	function automatic logic [11:0] shape(input logic [11:0] v, input logic m);
		logic [11:0] r;
		r = v;
		if (ts_en && !decim) begin
			if (narrow)
				r = {4'h0, v[11:4]};
			r[0] = m;
		end
		return r;
	endfunction : shape

	task automatic step();
		@(posedge mclk_in);
		#1;
	endtask : step

	task automatic wr(input logic [7:0] v);
		@(posedge mclk_in);
		coarse <= v;
		cwr <= 1'b1;
		@(posedge mclk_in);
		cwr <= 1'b0;
		#1;
	endtask : wr

	// Walks a ramp from the write edge, one step per gap cycles
	task automatic ramp(input int from, input int to, input int gap);
		int cur;
		cur = from;
		check("busy", 16'(busy), 16'h0001);
		while (cur != to) begin
			repeat (gap - 1) @(posedge mclk_in);
			#1;
			check("hold", 16'(ceff), 16'(cur));
			step();
			cur += (to > cur) ? 1 : -1;
			check("step", 16'(ceff), 16'(cur));
		end
		check("idle", 16'(busy), 16'h0000);
	endtask : ramp

	// Random core samples every clock
	always @(posedge mclk_in) begin
		cf <= 12'($random(seed));
		cs <= 12'($random(seed));
	end

	// Sample path model; quiet while reset or a mode change settles
	always @(posedge mclk_in) begin
		pin_q.push_back(trig);
		if (pin_q.size() > 16)
			void'(pin_q.pop_front());
		mk = (pin_q.size() >= LAT) ? pin_q[pin_q.size() - LAT] : 1'b0;
		if (!rstn_in)
			quiet = LAT + 3;
		else if (mode != {single, narrow, decim, ts_en})
			quiet = 2;
		else if (quiet > 0)
			quiet--;
		mode = {single, narrow, decim, ts_en};
		#1;
		if (quiet == 0) begin
			check("first", 16'(sf), 16'(ef));
			check("second", 16'(ss), 16'(es));
			check("fall", 16'(fall), 16'(efall));
		end
		ef = shape(cf, mk);
		es = shape(cs, mk);
		efall = single;
	end

	initial begin
		int w;
		repeat (10) @(posedge mclk_in);
		rstn_in <= 1'b1;
		// Every mode mix, marking set by software first
		for (int m = 0; m < 16; m++) begin
			@(posedge mclk_in);
			{single, narrow, decim, ts_en} <= 4'(m);
			repeat (30) @(posedge mclk_in);
		end
		// Invert and fine apply one cycle on, independent of coarse
		@(posedge mclk_in);
		inv <= 1'b1;
		fine <= 8'hFF;
		step();
		check("inv", 16'(inv_o), 16'h0001);
		check("fine", 16'(feff), 16'h00FF);
		wr(8'hFF);
		check("direct", 16'(ceff), 16'h00FF);
		@(posedge mclk_in);
		ramp_en <= 1'b1;
		wr(8'hFC);
		ramp(255, 252, 384);
		@(posedge mclk_in);
		speed <= 1'b1;
		wr(8'hF0);
		repeat (100) @(posedge mclk_in);
		#1;
		check("fast", 16'(ceff), 16'h00FB);
		wr(8'hFF);
		ramp(251, 255, 96);
		wr(8'h00);
		repeat (10) @(posedge mclk_in);
		ramp_en <= 1'b0;
		step();
		check("jump", 16'(ceff), 16'h0000);
		// Reference at twice the frame period stays clean, a slip flags
		@(posedge mclk_in);
		run <= 1'b1;
		repeat (200) step();
		check("err", 16'(serr), 16'h0000);
		@(posedge mclk_in);
		slip <= 1'b1;
		for (w = 0; w < 100 && serr !== 1'b1; w++)
			step();
		check("err", 16'(serr), 16'h0001);
		if (serr !== 1'b1)
			close_out();
		@(posedge mclk_in);
		run <= 1'b0;
		slip <= 1'b0;
		repeat (80) step();
		@(posedge mclk_in);
		eclr <= 1'b1;
		@(posedge mclk_in);
		eclr <= 1'b0;
		step();
		check("clr", 16'(serr), 16'h0000);
		close_out();
	end
endmodule : testbench

`default_nettype wire
